/* design/dpram_port_ctrl.sv */
// one-port controller driving the dual-port ram pins from user orders
// assumes the memory pins are asynchronous; busy and interrupt are synced
`timescale 1ns/1ps
module dpram_port_ctrl #(
  parameter int addr_bits = 16,
  parameter int data_bits = 18,
  parameter bit out_en_during_write = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user order
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dpram_host_pkg::cmd_t cmd,
  output logic rsp_valid,
  output logic [data_bits-1:0] rsp_data,
  // slave part: wait for busy before writes
  input wire logic slave_role,
  // own mailbox interrupt, synced and active high
  output logic interrupt_pending,
  // memory pins
  output dpram_host_pkg::port_ctl_t port_ctl,
  output logic [addr_bits-1:0] addr,
  output logic [data_bits-1:0] data_o,
  output logic data_oe,
  input wire logic [data_bits-1:0] data_i,
  input wire logic busy_n,
  input wire logic int_n
);
  import dpram_host_pkg::*;

  // refuse widths the packed order cannot carry
  if (addr_bits < 15 || addr_bits > addr_w || data_bits < 16 ||
      data_bits > data_w) begin : g_bad_width
    $error("unsupported port width");
  end

  typedef enum {idle, setup, wr_pulse, wr_end, rd_wait, gap} state_t;
  state_t state;
  logic [count_w-1:0] cnt;
  logic [addr_bits-1:0] last_waddr;
  logic recent_write;
  logic [count_w-1:0] flow_cnt;
  logic busy_s1, busy_s2, int_s1, int_s2;
  logic is_write, is_token;

  // busy and interrupt cross in through two flops each
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_s1 <= 1'b1;
      busy_s2 <= 1'b1;
      int_s1 <= 1'b1;
      int_s2 <= 1'b1;
    end else begin
      busy_s1 <= busy_n;
      busy_s2 <= busy_s1;
      int_s1 <= int_n;
      int_s2 <= int_s1;
    end
  end
  assign interrupt_pending = ~int_s2;

  assign cmd_ready = (state == idle);

  // latched order kind
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      is_write <= 1'b0;
      is_token <= 1'b0;
      addr <= '0;
      data_o <= '0;
    end else if (cmd_valid && cmd_ready) begin
      is_write <= cmd.write;
      is_token <= cmd.token;
      // token orders only use address bits 0..2
      addr <= cmd.token ? {{(addr_bits-token_addr_w){1'b0}},
        cmd.addr[token_addr_w-1:0]} : cmd.addr[addr_bits-1:0];
      // token write only bit zero matters; replicate for a clean bus
      data_o <= cmd.token ? {data_bits{cmd.wdata[0]}} :
        cmd.wdata[data_bits-1:0];
    end
  end

  // flowthrough guard: reads of the last written word wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_waddr <= '0;
      flow_cnt <= '0;
    end else if (state == wr_end) begin
      last_waddr <= addr;
      flow_cnt <= count_w'(flow_cyc);
    end else if (flow_cnt != '0) begin
      flow_cnt <= flow_cnt - 1'b1;
    end
  end
  assign recent_write = (flow_cnt != '0);

  // main sequencer; rw is only low inside a write pulse, so address
  // changes always happen with rw high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= idle;
      cnt <= '0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      port_ctl.chip_select_n <= 1'b1;
      port_ctl.token_latch_select_n <= 1'b1;
      port_ctl.rw <= 1'b1;
      port_ctl.output_enable_n <= 1'b1;
      port_ctl.upper_lane_enable_n <= 1'b1;
      port_ctl.lower_lane_enable_n <= 1'b1;
      data_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        idle: begin
          if (cmd_valid) begin
            state <= setup;
            cnt <= '0;
            // token orders keep both lanes off so chip select, token
            // select and a lane enable are never low together
            port_ctl.upper_lane_enable_n <= cmd.token | ~cmd.upper;
            port_ctl.lower_lane_enable_n <= cmd.token | ~cmd.lower;
          end
        end
        setup: begin
          // wait out flowthrough and, in slave role, busy settling
          if (is_write && slave_role && (!busy_s2 ||
              cnt < count_w'(busy_settle_cyc))) begin
            cnt <= (busy_s2) ? cnt + 1'b1 : '0;
          end else if (!is_write && recent_write &&
                       addr == last_waddr) begin
            cnt <= '0;
          end else begin
            // selects fall together with rw so outputs stay off
            port_ctl.rw <= ~is_write;
            port_ctl.chip_select_n <= is_token;
            port_ctl.token_latch_select_n <= ~is_token;
            port_ctl.output_enable_n <= is_write &
              ~out_en_during_write;
            data_oe <= is_write;
            cnt <= '0;
            state <= is_write ? wr_pulse : rd_wait;
          end
        end
        wr_pulse: begin
          // stretch when outputs are enabled through the write
          cnt <= cnt + 1'b1;
          if (cnt + 1'b1 >= count_w'(out_en_during_write ?
              stretch_cyc : pwe_cyc)) begin
            port_ctl.rw <= 1'b1;
            state <= wr_end;
          end
        end
        wr_end: begin
          // data held one cycle past the rising rw edge
          port_ctl.chip_select_n <= 1'b1;
          port_ctl.token_latch_select_n <= 1'b1;
          port_ctl.output_enable_n <= 1'b1;
          data_oe <= 1'b0;
          cnt <= '0;
          state <= gap;
        end
        rd_wait: begin
          cnt <= cnt + 1'b1;
          if (cnt + 1'b1 >= count_w'(access_cyc)) begin
            rsp_data <= data_i;
            rsp_valid <= 1'b1;
            // deselect after each read; token reads need a fresh select
            port_ctl.chip_select_n <= 1'b1;
            port_ctl.token_latch_select_n <= 1'b1;
            port_ctl.output_enable_n <= 1'b1;
            cnt <= '0;
            state <= gap;
          end
        end
        gap: begin
          // deselected gap lets token flags update before the next read
          cnt <= cnt + 1'b1;
          if (cnt + 1'b1 >= count_w'(token_gap_cyc))
            state <= idle;
        end
        default: state <= idle;
      endcase
    end
  end
endmodule

/* design/dpram_host_pkg.sv */
// constants and carrier types for the dual-port ram port controller
// assumes a 200 MHz clock and one asynchronous port of the memory outside
package dpram_host_pkg;
  localparam int clk_period_ps = 5000;
  // nanosecond figures of the slowest speed grade
  localparam int pwe_ns = 15;
  localparam int hzwe_ns = 12;
  localparam int sd_ns = 15;
  localparam int access_ns = 20;
  localparam int flowthrough_delay_ns = 30;
  localparam int flag_delay_from_match_ns = 20;
  localparam int token_pulse_ns = 10;
  // least times round up to whole cycles
  localparam int pwe_cyc = (pwe_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int stretch_cyc =
    ((hzwe_ns + sd_ns) * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int access_cyc =
    (access_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int flow_cyc =
    (flowthrough_delay_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int busy_settle_cyc =
    (flag_delay_from_match_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int token_gap_cyc =
    (token_pulse_ns * 1000 + clk_period_ps - 1) / clk_period_ps;
  localparam int count_w = 4;
  localparam int addr_w = 16;
  localparam int data_w = 18;
  localparam int token_addr_w = 3;

  // one order from the user side
  typedef struct packed {
    logic write;
    logic token;
    logic upper;
    logic lower;
    logic [addr_w-1:0] addr;
    logic [data_w-1:0] wdata;
  } cmd_t;

  // control pins of the port, all active low except rw
  typedef struct packed {
    logic chip_select_n;
    logic token_latch_select_n;
    logic rw;
    logic output_enable_n;
    logic upper_lane_enable_n;
    logic lower_lane_enable_n;
  } port_ctl_t;
endpackage

/* testbench/dpram_dev_model.sv */
// one port of the dual-port ram: word array plus eight token latches
// assumes one controller here; the far port only raises our interrupt
`timescale 1ns/1ps
module dpram_dev_model (
  // controller pins
  input wire dpram_host_pkg::port_ctl_t port_ctl,
  input wire logic [15:0] addr,
  input wire logic [17:0] data_o,
  input wire logic busy_n,
  // far port writes our mailbox
  input wire logic set_int,
  // back to the controller
  output logic [17:0] data_i,
  output logic int_n = 1'b1
);
  import dpram_host_pkg::*;
  logic [17:0] mem [65536];
  logic [7:0] token = 8'hff;
  logic ul, ll, ram_sel, tok_sel, rd_on;
  assign ul = port_ctl.upper_lane_enable_n;
  assign ll = port_ctl.lower_lane_enable_n;
  // both selects low at once is refused, so no word or token latch is written then
  assign ram_sel = !port_ctl.chip_select_n && port_ctl.token_latch_select_n
    && !(ul && ll);
  assign tok_sel = port_ctl.chip_select_n
    && !port_ctl.token_latch_select_n;
  assign rd_on = port_ctl.rw && !port_ctl.output_enable_n;
  // stores on the rising rw edge; busy from the far arbiter drops word stores, not token stores
  always @(posedge port_ctl.rw) begin
    if (ram_sel && busy_n && !ul) mem[addr][17:9] = data_o[17:9];
    if (ram_sel && busy_n && !ll) mem[addr][8:0] = data_o[8:0];
    if (tok_sel) token[addr[2:0]] = data_o[0];
  end
  // released lines show the inverted word, never the stale one
  always_comb begin
    if (rd_on && ram_sel) data_i = mem[addr];
    else if (rd_on && tok_sel) data_i = {18{token[addr[2:0]]}};
    else data_i = ~mem[addr];
  end
  // far port writes our mailbox; busy stands for the far arbiter
  always @(posedge set_int) int_n = 1'b0;
  // own mailbox read clears, but not while busy holds the port
  always @(negedge port_ctl.chip_select_n)
    if (port_ctl.rw && addr == 16'hfffe && busy_n) int_n = 1'b1;
  // busy_n models the outcome of the arbitration of the far side
endmodule

/* testbench/dpram_port_ctrl_assertions.sv */
// pin-level checks on the dual-port ram controller
// assumes it is bound to the controller and sees only its ports
`timescale 1ns/1ps
module dpram_port_ctrl_assertions #(parameter int addr_bits = 16) (
  // clock, reset, role, busy
  input wire logic clk,
  input wire logic rst,
  input wire logic slave_role,
  input wire logic busy_n,
  // memory pins
  input wire dpram_host_pkg::port_ctl_t port_ctl,
  input wire logic [addr_bits-1:0] addr,
  input wire logic data_oe
);
  import dpram_host_pkg::*;
  logic cs, ts, rw;
  assign cs = port_ctl.chip_select_n;
  assign ts = port_ctl.token_latch_select_n;
  assign rw = port_ctl.rw;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  addr_rw_a: assert property ($changed(addr) |-> rw)
    else $error("address moved during write");
  no_clash_a: assert property (!(data_oe && rw && !port_ctl.output_enable_n))
    else $error("drove data over read data");
  sel_legal_a: assert property (!cs |-> ts &&
    !(port_ctl.upper_lane_enable_n && port_ctl.lower_lane_enable_n))
    else $error("bad select mix");
  tok_cs_a: assert property ($fell(ts) |-> cs [*4])
    else $error("chip select low in token cycle");
  tok_addr_a: assert property (!ts |-> addr[addr_bits-1:3] == '0)
    else $error("token address high bits set");
  read_rw_a: assert property ($fell(cs) && rw |-> rw [*4])
    else $error("rw dropped during read");
  write_pulse_a: assert property ($fell(rw) |->
    (!rw && data_oe) [*3] ##1 (rw && data_oe))
    else $error("write pulse or data hold wrong");
  slave_wait_a: assert property ($fell(rw) && slave_role |->
    $past(busy_n, 3)) else $error("slave write while busy");
  cover property ($fell(cs) && rw);
  cover property ($fell(rw) && !cs);
  cover property ($fell(ts));
endmodule
bind dpram_port_ctrl dpram_port_ctrl_assertions #(.addr_bits(addr_bits)) chk (
  .clk(clk), .rst(rst), .slave_role(slave_role), .busy_n(busy_n),
  .port_ctl(port_ctl), .addr(addr), .data_oe(data_oe));

/* testbench/test_dual_port_ram_arbitration.sv */
// self-checking bench for the dual-port ram controller
// assumes the device model of this folder on the pin side
`timescale 1ns/1ps
module test_dual_port_ram_arbitration;
  import dpram_host_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, slave_role = 1'b0;
  logic busy_n = 1'b1, set_int = 1'b0, cmd_ready, rsp_valid, pend, oe;
  logic int_n;
  logic [17:0] rsp_data, d_o, d_i, w1, w2;
  logic [15:0] a, a_pin;
  port_ctl_t ctl;
  cmd_t cmd = '0;
  int bad_count = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  dpram_port_ctrl DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .slave_role(slave_role), .interrupt_pending(pend),
    .port_ctl(ctl), .addr(a_pin), .data_o(d_o), .data_oe(oe),
    .data_i(d_i), .busy_n(busy_n), .int_n(int_n));
  dpram_dev_model dev (.port_ctl(ctl), .addr(a_pin), .data_o(d_o),
    .busy_n(busy_n), .set_int(set_int), .data_i(d_i), .int_n(int_n));
  task automatic check(logic [17:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // upper lane from the new word, lower lane kept
  function automatic logic [17:0] mix(logic [17:0] old, nw);
    return {nw[17:9], old[8:0]};
  endfunction
  // offer an order at a falling edge, drop it after the taking edge
  task automatic issue(logic wr, tk, up, lo, logic [15:0] ad,
    logic [17:0] wd);
    repeat (200) if (!cmd_ready) @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{wr, tk, up, lo, ad, wd};
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic rd(logic tk, logic [15:0] ad, logic [17:0] exp);
    issue(1'b0, tk, 1'b1, 1'b1, ad, 18'h0);
    repeat (40) if (!rsp_valid) @(negedge clk);
    check(rsp_data, exp);
  endtask
  initial begin
    void'($urandom(52));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    // full word, then upper lane only, each read back at once
    repeat (20) begin
      a = 16'($urandom_range(16'hfffd));
      w1 = 18'($urandom);
      w2 = 18'($urandom);
      issue(1'b1, 1'b0, 1'b1, 1'b1, a, w1);
      rd(1'b0, a, w1);
      issue(1'b1, 1'b0, 1'b1, 1'b0, a, w2);
      rd(1'b0, a, mix(w1, w2));
    end
    // claim then release every latch; high address bits are noise
    for (int k = 0; k < 8; k++) begin
      a = {13'($urandom), 3'(k)};
      issue(1'b1, 1'b1, 1'b0, 1'b0, a, 18'h3fffe);
      rd(1'b1, a, 18'h0);
      issue(1'b1, 1'b1, 1'b0, 1'b0, a, 18'h1);
      rd(1'b1, a, 18'h3ffff);
    end
    // mailbox: busy blocks the clearing read, a free read clears
    issue(1'b1, 1'b0, 1'b1, 1'b1, 16'hfffe, w1);
    // let the mailbox write land before busy is lowered
    repeat (12) @(negedge clk);
    set_int = 1'b1;
    busy_n = 1'b0;
    rd(1'b0, 16'hfffe, w1);
    repeat (4) @(negedge clk);
    check(18'(pend), 18'h1);
    busy_n = 1'b1;
    rd(1'b0, 16'hfffe, w1);
    repeat (4) @(negedge clk);
    check(18'(pend), 18'h0);
    // slave role: the write waits until busy from the master rises
    slave_role = 1'b1;
    busy_n = 1'b0;
    issue(1'b1, 1'b0, 1'b1, 1'b1, a, w2);
    repeat (20) @(negedge clk);
    check(18'(ctl.rw), 18'h1);
    busy_n = 1'b1;
    rd(1'b0, a, w2);
    conclude();
  end
  // watchdog at several times the expected run
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule
